// File: bench/cfcc_bus_node.sv
// Other nodes on the shared bus: bit levels with a slow sample strobe.
// Assumes the counters block synchronises both lines to clk_sys.
`timescale 1ns/1ps
module cfcc_bus_node (
    output logic bus_rx_pin,
    output logic bit_tick,
    input wire logic clk_sys
);
    initial begin
        bus_rx_pin = 1'b1;
        bit_tick = 1'b0;
    end
    ////////////////////////////////////////
    // Strobe stands three cycles high and four low so the two-flop sync never misses it
    task automatic bits(input logic lvl, input int n);
        repeat (n) begin
            @(negedge clk_sys);
            bus_rx_pin = lvl;
            repeat (3) @(negedge clk_sys);
            bit_tick = 1'b1;
            repeat (3) @(negedge clk_sys);
            bit_tick = 1'b0;
        end
        // Released bus returns to recessive through the pull-up
        bus_rx_pin = 1'b1;
    endtask
endmodule // cfcc_bus_node

// File: bench/cfcc_counters_props.sv
// Checker for the fault-confinement counters, top ports only.
// Assumes one clock domain; bound onto cfcc_counters below.
`timescale 1ns/1ps
module cfcc_counters_props (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic init_mode,
    input wire logic auto_bus_on_enable,
    input wire logic power_down_entered,
    input wire logic engine_rx_busy,
    input wire logic engine_tx_busy,
    input wire logic bus_rx_pin,
    input wire logic bit_tick,
    input wire logic tx_err,
    input wire logic tx_err_passive_ack,
    input wire logic tx_ok,
    input wire logic rx_err,
    input wire logic rx_err_severe,
    input wire logic rx_ok,
    input wire logic [31:0] transmit_error_count_reg,
    input wire logic [31:0] receive_error_count_reg,
    input wire logic [31:0] status_reg,
    input wire logic bus_drive_enable
);
    logic [1:0] up;
    // Outputs are only meaningful once the reset synchroniser has let go
    wire logic rdy = up == 2'h3;
    wire logic [7:0] tx_err_count = transmit_error_count_reg[7:0];
    wire logic [7:0] rx_err_count = receive_error_count_reg[7:0];
    wire logic [3:0] evs = {tx_err, tx_ok, rx_err, rx_ok};
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) up <= 2'h0;
        else if (!rdy) up <= up + 2'h1;
    end
    ////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence one(a);
        rdy && evs == 4'h0 && !init_mode ##1 a && $onehot(evs) && !status_reg[18];
    endsequence
    activity_a: assert property (rdy |=> status_reg[3:0] == {$past(power_down_entered), 1'b0,
        $past(engine_rx_busy), $past(engine_tx_busy)}) else $error("activity bits wrong");
    upper_zero_a: assert property (rdy |-> transmit_error_count_reg[31:8] == 24'h0
        && receive_error_count_reg[31:8] == 24'h0) else $error("upper bits set");
    tx_add_a: assert property (one(tx_err && !tx_err_passive_ack && tx_err_count < 8'hF8) |-> ##2
        tx_err_count == $past(tx_err_count, 2) + 8'h08) else $error("tx error step wrong");
    rx_cap_a: assert property (one(rx_err && rx_err_count >= 8'h80) |-> ##2 rx_err_count == $past(rx_err_count, 2))
        else $error("rx count rose when passive");
    rx_reload_a: assert property (one(rx_ok && rx_err_count >= 8'h80) |-> ##2 rx_err_count == 8'h77)
        else $error("rx reload wrong");
    busoff_entry_a: assert property (rdy && $rose(status_reg[18]) |-> rx_err_count == 8'h00
        && !bus_drive_enable) else $error("bus-off entry wrong");
    auto_on_a: assert property (rdy && status_reg[18] && rx_err_count == 8'h80 && auto_bus_on_enable
        |-> ##[1:3] (!status_reg[18] && tx_err_count == 8'h00 && rx_err_count == 8'h00 && bus_drive_enable))
        else $error("no auto bus-on");
    init_clear_a: assert property (rdy && $fell(init_mode) |-> ##[1:3] (tx_err_count == 8'h00
        && rx_err_count == 8'h00)) else $error("init leave no clear");
    flags_a: assert property (rdy && !status_reg[18] |-> status_reg[16] == (tx_err_count >= 8'h60
        || rx_err_count >= 8'h60) && status_reg[17] == (tx_err_count >= 8'h80)) else $error("flags wrong");
endmodule // cfcc_counters_props
bind cfcc_counters cfcc_counters_props cfcc_counters_props_inst (.*);

// File: bench/cfcc_counters_tb.sv
// Self-checking bench for the fault-confinement counters.
// Assumes the bus node model and the bound checker are compiled first.
`timescale 1ns/1ps
module cfcc_counters_tb;
    import cfcc_pkg::*;
    logic clk_sys = 0, nrst = 0, init_mode = 0, auto_bus_on_enable = 0, power_down_entered = 0;
    logic engine_rx_busy = 0, engine_tx_busy = 0, bus_rx_pin, bit_tick, bus_drive_enable;
    logic tx_err = 0, tx_err_passive_ack = 0, tx_ok = 0, rx_err = 0, rx_err_severe = 0, rx_ok = 0;
    logic [31:0] transmit_error_count_reg, receive_error_count_reg, status_reg;
    int errors = 0, checks = 0, seed = 95938, tx_err_count = 0, rx_err_count = 0, bo = 0, k;
    always #25 clk_sys = ~clk_sys;
    cfcc_counters cfcc_counters_inst (.*);
    cfcc_bus_node cfcc_bus_node_inst (.*);
    ////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task regs;
        check(transmit_error_count_reg, {24'h0, tx_err_count[7:0]});
        check(receive_error_count_reg, {24'h0, rx_err_count[7:0]});
        check(32'(status_reg[18]), bo);
        check(32'(status_reg[16]), 32'(!bo && (tx_err_count >= 96 || rx_err_count >= 96)));
        if (!bo) check(32'(status_reg[17]), 32'(tx_err_count >= 128));
    endtask
    // Model step is taken with the pulse; counts show two edges later
    task ev(input int kind);
        @(negedge clk_sys);
        {tx_err, tx_err_passive_ack, tx_ok} = {kind < 2, kind == 1, kind == 2};
        {rx_err, rx_err_severe, rx_ok} = {kind == 3 || kind == 4, kind == 4, kind == 5};
        if (!bo) case (kind)
            0, 1: if (kind == 0 || tx_err_count < 128) begin
                if (tx_err_count + 8 > 255) {bo, rx_err_count} = {32'd1, 32'd0};
                else tx_err_count += 8;
            end
            2: if (tx_err_count > 0) tx_err_count--;
            3: if (rx_err_count < 128) rx_err_count++;
            4: if (rx_err_count < 128) rx_err_count += 8;
            default: rx_err_count = rx_err_count >= 128 ? 119 : (rx_err_count > 0 ? rx_err_count - 1 : 0);
        endcase
        @(negedge clk_sys);
        {tx_err, tx_err_passive_ack, tx_ok, rx_err, rx_err_severe, rx_ok} = 6'h00;
        @(negedge clk_sys);
        regs();
    endtask
    initial begin
        repeat (12) @(negedge clk_sys);
        nrst = 1;
        repeat (3) @(negedge clk_sys);
        regs();
        for (k = 0; k < 8; k++) begin
            {power_down_entered, engine_rx_busy, engine_tx_busy} = k[2:0];
            @(negedge clk_sys);
            check(32'(status_reg[3:0]), 32'({k[2], 1'b0, k[1:0]}));
        end
        repeat (120) ev($unsigned($random(seed)) % 6);
        init_mode = 1;
        repeat (2) @(negedge clk_sys);
        init_mode = 0;
        {tx_err_count, rx_err_count} = 0;
        repeat (3) @(negedge clk_sys);
        regs();
        while (!bo) ev(0);
        check(32'(bus_drive_enable), 32'h0);
        cfcc_bus_node_inst.bits(1'b1, 10);
        cfcc_bus_node_inst.bits(1'b0, 1);
        repeat (4) @(negedge clk_sys);
        regs();
        cfcc_bus_node_inst.bits(1'b1, 1408);
        rx_err_count = 128;
        repeat (4) @(negedge clk_sys);
        regs();
        auto_bus_on_enable = 1;
        {bo, tx_err_count, rx_err_count} = 0;
        repeat (4) @(negedge clk_sys);
        regs();
        check(32'(bus_drive_enable), 32'h1);
        print_verdict();
    end
    initial begin
        #1500000;
        errors++;
        print_verdict();
    end
endmodule // cfcc_counters_tb

// File: core/cfcc_counters.sv
// Top of the CAN fault-confinement counters and activity status.
// Assumes protocol-engine event strobes are one cycle wide on clk_sys;
// the bus level and bit strobe come from the pin side and are synchronised here.
`timescale 1ns/1ps
`include "cfcc_params.svh"
module cfcc_counters
    import cfcc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic init_mode,
    input wire logic auto_bus_on_enable,
    input wire logic power_down_entered,
    input wire logic engine_rx_busy,
    input wire logic engine_tx_busy,
    input wire logic bus_rx_pin,
    input wire logic bit_tick,
    input wire logic tx_err,
    input wire logic tx_err_passive_ack,
    input wire logic tx_ok,
    input wire logic rx_err,
    input wire logic rx_err_severe,
    input wire logic rx_ok,
    output logic [31:0] transmit_error_count_reg,
    output logic [31:0] receive_error_count_reg,
    output logic [31:0] status_reg,
    output logic bus_drive_enable
);
    import cfcc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers

    logic rst_s1, rst_n;
    logic pin_s1, pin_s2;
    logic tick_s1, tick_s2, tick_s3;
    logic init_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
            tick_s1 <= 1'b0;
            tick_s2 <= 1'b0;
            tick_s3 <= 1'b0;
            init_q <= 1'b1;
        end else begin
            pin_s1 <= bus_rx_pin;
            pin_s2 <= pin_s1;
            tick_s1 <= bit_tick;
            tick_s2 <= tick_s1;
            tick_s3 <= tick_s2;
            init_q <= init_mode;
        end
    end

    wire tick_rise = tick_s2 & ~tick_s3;
    wire init_leave = init_q & ~init_mode;

    ////////////////////////////////////////////////////////////////////
    // Counter update

    cfcc_state_t state, next_state;
    cfcc_count_t tx_err_count, rx_err_count, next_tec, next_rec;
    logic gap_seen;

    cfcc_if gap_bus ();
    assign gap_bus.bit_tick = tick_rise;
    assign gap_bus.bus_bit = pin_s2;
    assign gap_bus.arm = (state == CFCC_BUS_OFF);
    assign gap_seen = gap_bus.gap_pulse;

    cfcc_gap_det u_gap (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .gap(gap_bus.det)
    );

    wire rec_passive = (rx_err_count >= `CFCC_PASSIVE_LEVEL);
    wire [8:0] tec_plus8 = {1'b0, tx_err_count} + 9'h008;
    wire tec_over = tec_plus8[8];
    // Passive ack-error exception leaves TX_ERR_COUNT alone, so it can never cause bus-off
    wire tx_hit = tx_err & ~(tx_err_passive_ack & (state == CFCC_ERR_PASSIVE));
    wire busoff_go = tx_hit & tec_over;
    wire [8:0] rec_plus8 = {1'b0, rx_err_count} + 9'h008;
    wire [7:0] rec_sat8 = rec_plus8[8] ? 8'hFF : rec_plus8[7:0];
    wire recovered = (rx_err_count == `CFCC_BUSOFF_DONE) & auto_bus_on_enable;

    always_comb begin
        next_state = state;
        next_tec = tx_err_count;
        next_rec = rx_err_count;
        if (init_leave) begin
            next_tec = `CFCC_TEC_RESET;
            next_rec = `CFCC_REC_RESET;
            if (state != CFCC_BUS_OFF) begin
                next_state = CFCC_ERR_ACTIVE;
            end
        end else begin
            case (state)
                CFCC_BUS_OFF: begin
                    if (recovered) begin
                        next_state = CFCC_ERR_ACTIVE;
                        next_tec = `CFCC_TEC_RESET;
                        next_rec = `CFCC_REC_RESET;
                    end else if (gap_seen && rx_err_count < `CFCC_BUSOFF_DONE) begin
                        next_rec = rx_err_count + 8'h01;
                    end
                end
                default: begin
                    // Transmit side, fault-confinement increments of 8 and decrement of 1
                    if (busoff_go) begin
                        next_state = CFCC_BUS_OFF;
                        next_tec = tx_err_count; // Undefined in bus-off; held as is
                        next_rec = `CFCC_REC_RESET;
                    end else if (tx_hit) begin
                        next_tec = tec_plus8[7:0];
                    end else if (!tx_err && tx_ok && tx_err_count != 8'h00) begin
                        next_tec = tx_err_count - 8'h01;
                    end
                    if (!busoff_go) begin
                        if (rx_err && !rec_passive) begin
                            next_rec = rx_err_severe ? rec_sat8 : rx_err_count + 8'h01;
                        end else if (rx_ok) begin
                            if (rec_passive) begin
                                next_rec = `CFCC_REC_RELOAD;
                            end else if (rx_err_count != 8'h00) begin
                                next_rec = rx_err_count - 8'h01;
                            end
                        end
                        next_state = (next_tec >= `CFCC_PASSIVE_LEVEL) ?
                            CFCC_ERR_PASSIVE : CFCC_ERR_ACTIVE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= CFCC_ERR_ACTIVE;
            tx_err_count <= `CFCC_TEC_RESET;
            rx_err_count <= `CFCC_REC_RESET;
        end else begin
            state <= next_state;
            tx_err_count <= next_tec;
            rx_err_count <= next_rec;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read-only views; the reserved bit is not writable and reads zero

    wire warn = (state != CFCC_BUS_OFF) &&
        (tx_err_count >= `CFCC_WARN_LEVEL || rx_err_count >= `CFCC_WARN_LEVEL);
    logic [31:0] next_status;

    always_comb begin
        next_status = 32'h0000_0000;
        next_status[`CFCC_STAT_TX_BIT] = engine_tx_busy;
        next_status[`CFCC_STAT_RX_BIT] = engine_rx_busy;
        next_status[`CFCC_STAT_RSV_BIT] = 1'b0;
        next_status[`CFCC_STAT_PDA_BIT] = power_down_entered;
        next_status[`CFCC_STAT_EW_BIT] = warn;
        next_status[`CFCC_STAT_EP_BIT] = (state == CFCC_ERR_PASSIVE);
        next_status[`CFCC_STAT_BO_BIT] = (state == CFCC_BUS_OFF);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            transmit_error_count_reg <= 32'h0000_0000;
            receive_error_count_reg <= 32'h0000_0000;
            status_reg <= 32'h0000_0000;
            bus_drive_enable <= 1'b0;
        end else begin
            transmit_error_count_reg <= {24'h00_0000, tx_err_count};
            receive_error_count_reg <= {24'h00_0000, rx_err_count};
            status_reg <= next_status;
            bus_drive_enable <= (state != CFCC_BUS_OFF);
        end
    end
endmodule // cfcc_counters

// File: core/cfcc_gap_det.sv
// Detects runs of eleven recessive sampled bits.
// Assumes bit_tick is a one-cycle sample strobe from the bit timing.
`timescale 1ns/1ps
`include "cfcc_params.svh"
module cfcc_gap_det
    import cfcc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    cfcc_if.det gap
);
    logic [3:0] run;
    logic gap_q;
    wire at_end = (run == (`CFCC_IDLE_BITS - 4'h1));
    wire recessive = gap.bus_bit;

    // Counter restarts after each gap so back-to-back gaps each count
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            run <= 4'h0;
            gap_q <= 1'b0;
        end else begin
            gap_q <= 1'b0;
            if (!gap.arm) begin
                run <= 4'h0;
            end else if (gap.bit_tick) begin
                if (!recessive) begin
                    run <= 4'h0;
                end else if (at_end) begin
                    run <= 4'h0;
                    gap_q <= 1'b1;
                end else begin
                    run <= run + 4'h1;
                end
            end
        end
    end

    assign gap.gap_pulse = gap_q;
endmodule // cfcc_gap_det

// File: core/cfcc_if.sv
// Carrier between the top and its idle-gap detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface cfcc_if;
    logic bit_tick;
    logic bus_bit;
    logic arm;
    logic gap_pulse;
    modport top (output bit_tick, output bus_bit, output arm, input gap_pulse);
    modport det (input bit_tick, input bus_bit, input arm, output gap_pulse);
endinterface // cfcc_if

// File: core/cfcc_params.svh
// Constants for the CAN fault-confinement counter block.
// Assumes inclusion by bare name from core/ files only.
`ifndef CFCC_PARAMS_SVH
`define CFCC_PARAMS_SVH

`define CFCC_TEC_RESET 8'h00
`define CFCC_REC_RESET 8'h00
`define CFCC_WARN_LEVEL 8'h60
`define CFCC_PASSIVE_LEVEL 8'h80
`define CFCC_REC_RELOAD 8'h77
`define CFCC_BUSOFF_DONE 8'h80
`define CFCC_IDLE_BITS 4'hB
`define CFCC_STAT_TX_BIT 0
`define CFCC_STAT_RX_BIT 1
`define CFCC_STAT_RSV_BIT 2
`define CFCC_STAT_PDA_BIT 3
`define CFCC_STAT_EW_BIT 16
`define CFCC_STAT_EP_BIT 17
`define CFCC_STAT_BO_BIT 18

`endif

// File: core/cfcc_pkg.sv
// Types shared by the fault-confinement counter files.
// Assumes the params header is compiled alongside.
package cfcc_pkg;
    typedef enum logic [1:0] {
        CFCC_ERR_ACTIVE = 2'b00,
        CFCC_ERR_PASSIVE = 2'b01,
        CFCC_BUS_OFF = 2'b10
    } cfcc_state_t;

    typedef logic [7:0] cfcc_count_t;
endpackage
